/* src/sspi_core.sv */
/*
 * receive payload pointer interpreter with a wishbone register slave.
 * assumes the framer on CLK_I strobes each h1/h2 word of a frame,
 * marks the primary one, and pulses frame end once per frame.
 */
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ns
module sspi_core (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // wishbone slave
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // pointer words from the framer
   input wire sspi_pkg::sspi_ptrw_t PTR_WORD_I,
   input wire logic PTR_VALID_I,
   input wire logic PTR_FIRST_I,
   input wire logic FRAME_END_I,
   // status and interrupts
   output sspi_pkg::sspi_state_t PTR_STATE_O,
   output logic [9:0] PTR_VALUE_O,
   output logic INT_A_O,
   output logic INT_B_O
);
   import sspi_pkg::*;

   function automatic logic [3:0] ones10(input logic [9:0] x);
      logic [3:0] n;
      n = 4'h0;
      for (int k = 0; k < 10; k++) begin
         n = n + {3'h0, x[k]};
      end
      return n;
   endfunction

   function automatic logic maj4(input logic [3:0] f, input logic [3:0] p);
      logic [3:0] d;
      d = f ^ p;
      return ({2'b0, d[0]} + {2'b0, d[1]} + {2'b0, d[2]} + {2'b0, d[3]})
         <= 3'h1;
   endfunction

   logic [CTL_W-1:0] ctrl_q;
   logic sdh;
   assign sdh = ctrl_q[CTL_SDH];

   // word capture within the frame
   sspi_ptrw_t prim_q;
   logic prim_seen_q;
   logic ci_bad_q;
   logic [7:0] word_idx_q;
   logic [7:0] word_lim;
   logic ci_pointer_normal_state, ci_ais;
   assign word_lim = sdh ? WORDS_SDH : WORDS_SONET;
   assign ci_pointer_normal_state = maj4(PTR_WORD_I.flag, FLAG_NORMAL) &&
      PTR_WORD_I.value == VALUE_ONES &&
      (!sdh || PTR_WORD_I.size == SIZE_SDH);
   assign ci_ais = PTR_WORD_I == WORD_AIS;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         prim_q <= '0;
         prim_seen_q <= 1'b0;
         ci_bad_q <= 1'b0;
         word_idx_q <= 8'h00;
      end else if (PTR_VALID_I && PTR_FIRST_I) begin
         prim_q <= PTR_WORD_I;
         prim_seen_q <= 1'b1;
         ci_bad_q <= 1'b0;
         word_idx_q <= 8'h01;
      end else if (FRAME_END_I) begin
         prim_seen_q <= 1'b0;
         ci_bad_q <= 1'b0;
         word_idx_q <= 8'h00;
      end else if (PTR_VALID_I && word_idx_q != 8'h00) begin
         word_idx_q <= word_idx_q + 8'h01;
         if (word_idx_q < word_lim && !ci_pointer_normal_state && !ci_ais) begin
            ci_bad_q <= 1'b1;
         end
      end
   end

   // classification of the primary word, evaluated at frame end
   sspi_state_t state_q;
   logic [9:0] cur_q;
   logic [1:0] hold_q;
   logic eval, ss_ok, in_rng, p_ais, p_pointer_normal_state, p_ndf, pointer_normal_state_eq;
   logic [3:0] inv_i, inv_d;
   logic inc_hit, dec_hit, inc_ok, dec_ok, ndf_take, valid;
   logic [9:0] diff, inc_val, dec_val;

   assign eval = FRAME_END_I;
   assign ss_ok = !sdh || prim_q.size == SIZE_SDH;
   assign in_rng = prim_q.value <= VALUE_MAX;
   assign p_ais = prim_seen_q && prim_q == WORD_AIS;
   assign p_pointer_normal_state = prim_seen_q && maj4(prim_q.flag, FLAG_NORMAL) &&
      in_rng && ss_ok;
   assign p_ndf = prim_seen_q && maj4(prim_q.flag, FLAG_NDF) &&
      in_rng && ss_ok;
   assign pointer_normal_state_eq = p_pointer_normal_state && prim_q.value == cur_q;
   assign diff = prim_q.value ^ cur_q;
   assign inv_i = ones10(diff & I_BITS);
   assign inv_d = ones10(diff & D_BITS);

   always_comb begin
      if (sdh) begin
         inc_hit = inv_i >= SDH_MAJ && inv_d < SDH_MAJ;
         dec_hit = inv_d >= SDH_MAJ && inv_i < SDH_MAJ;
      end else begin
         inc_hit = ones10(diff ^ I_BITS) <= SONET_MAX_DIFF;
         dec_hit = ones10(diff ^ D_BITS) <= SONET_MAX_DIFF;
      end
   end

   // justification only from the normal flag in normal state
   assign inc_ok = prim_seen_q && maj4(prim_q.flag, FLAG_NORMAL) &&
      ss_ok && !pointer_normal_state_eq && state_q == ST_POINTER_NORMAL_STATE && hold_q == 2'h0 &&
      inc_hit;
   assign dec_ok = prim_seen_q && maj4(prim_q.flag, FLAG_NORMAL) &&
      ss_ok && !pointer_normal_state_eq && state_q == ST_POINTER_NORMAL_STATE && hold_q == 2'h0 &&
      dec_hit && !inc_hit;
   assign ndf_take = p_ndf && state_q == ST_POINTER_NORMAL_STATE;
   assign inc_val = (cur_q == VALUE_MAX) ? VALUE_ZERO :
      cur_q + 10'h001;
   assign dec_val = (cur_q == VALUE_ZERO) ? VALUE_MAX :
      cur_q - 10'h001;

   always_comb begin
      case (state_q)
         ST_AIS: valid = p_ais;
         ST_POINTER_NORMAL_STATE: valid = !ci_bad_q &&
            (pointer_normal_state_eq || ndf_take || inc_ok || dec_ok);
         default: valid = 1'b0;
      endcase
   end

   // persistence counters
   logic [9:0] cand_q;
   logic [1:0] pointer_normal_state_cnt_q, ais_cnt_q;
   logic [3:0] inv_cnt_q;
   logic norm3, ais3, inv8;
   assign norm3 = p_pointer_normal_state && prim_q.value == cand_q &&
      pointer_normal_state_cnt_q == PERSIST_3 - 2'h1;
   assign ais3 = p_ais && ais_cnt_q == PERSIST_3 - 2'h1;
   assign inv8 = !valid && inv_cnt_q == PERSIST_8 - 4'h1;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cand_q <= VALUE_ZERO;
         pointer_normal_state_cnt_q <= 2'h0;
      end else if (eval) begin
         if (!p_pointer_normal_state) begin
            pointer_normal_state_cnt_q <= 2'h0;
         end else if (prim_q.value == cand_q && pointer_normal_state_cnt_q != 2'h0) begin
            if (pointer_normal_state_cnt_q != PERSIST_3) begin
               pointer_normal_state_cnt_q <= pointer_normal_state_cnt_q + 2'h1;
            end
         end else begin
            cand_q <= prim_q.value;
            pointer_normal_state_cnt_q <= 2'h1;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ais_cnt_q <= 2'h0;
      end else if (eval) begin
         if (!p_ais) begin
            ais_cnt_q <= 2'h0;
         end else if (ais_cnt_q != PERSIST_3) begin
            ais_cnt_q <= ais_cnt_q + 2'h1;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         inv_cnt_q <= 4'h0;
      end else if (eval) begin
         // a fresh state starts its own run of invalid frames
         if (valid || state_q == ST_LOP || norm3 ||
            (ais3 && state_q != ST_AIS)) begin
            inv_cnt_q <= 4'h0;
         end else if (inv_cnt_q != PERSIST_8) begin
            inv_cnt_q <= inv_cnt_q + 4'h1;
         end
      end
   end

   // tracking state; alarm entry outranks normal, normal outranks loss
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state_q <= ST_LOP;
      end else if (eval) begin
         if (ais3 && state_q != ST_AIS) begin
            state_q <= ST_AIS;
         end else if (norm3) begin
            state_q <= ST_POINTER_NORMAL_STATE;
         end else if (inv8 && state_q != ST_LOP) begin
            state_q <= ST_LOP;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cur_q <= VALUE_ZERO;
      end else if (eval) begin
         if (ais3 && state_q != ST_AIS) begin
            cur_q <= cur_q;
         end else if (norm3) begin
            cur_q <= prim_q.value;
         end else if (ndf_take) begin
            cur_q <= prim_q.value;
         end else if (inc_ok) begin
            cur_q <= inc_val;
         end else if (dec_ok) begin
            cur_q <= dec_val;
         end
      end
   end

   // holdoff after an accepted new data pointer or justification step, not after three equal pointers
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         hold_q <= 2'h0;
      end else if (eval) begin
         if (ndf_take || inc_ok || dec_ok) begin
            hold_q <= HOLDOFF_FRAMES;
         end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
         end
      end
   end

   // state change events
   logic was_ais_q, was_lop_q, alm_chg, loss_chg;
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         was_ais_q <= 1'b0;
         was_lop_q <= 1'b1;
      end else begin
         was_ais_q <= state_q == ST_AIS;
         was_lop_q <= state_q == ST_LOP;
      end
   end
   assign alm_chg = was_ais_q != (state_q == ST_AIS);
   assign loss_chg = was_lop_q != (state_q == ST_LOP);

   // wishbone slave: data and read side effects at the request edge,
   // ack one cycle later, so an event in the read cycle is never lost
   logic req, rd_take, wr_take, hit_latch, hit_pend;
   logic [1:0] latch_q, pend_q, now_st;
   assign req = CYC_I && STB_I && !ACK_O;
   assign rd_take = req && !WE_I;
   assign wr_take = CYC_I && STB_I && WE_I && ACK_O;
   assign hit_latch = rd_take && ADR_I == REG_LATCH;
   assign hit_pend = rd_take && ADR_I == REG_PEND;
   assign now_st = {state_q == ST_LOP, state_q == ST_AIS};

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ACK_O <= 1'b0;
      end else begin
         ACK_O <= req;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         DAT_O <= 32'h00000000;
      end else if (rd_take) begin
         case (ADR_I)
            REG_CTRL: DAT_O <= {27'h0000000, ctrl_q};
            REG_LATCH: DAT_O <= {30'h00000000, latch_q};
            REG_PEND: DAT_O <= {30'h00000000, pend_q};
            REG_PTR: DAT_O <= {17'h00000, state_q, 2'h0, cur_q};
            default: DAT_O <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_take && ADR_I == REG_CTRL && SEL_I[0]) begin
         ctrl_q <= DAT_I[CTL_W-1:0];
      end
   end

   // latch-high bits: event first, then present status on next read
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         latch_q <= 2'h0;
      end else begin
         latch_q[EV_ALM] <= alm_chg ||
            (hit_latch ? now_st[EV_ALM] : latch_q[EV_ALM]);
         latch_q[EV_LOSS] <= loss_chg ||
            (hit_latch ? now_st[EV_LOSS] : latch_q[EV_LOSS]);
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pend_q <= 2'h0;
      end else begin
         pend_q[EV_ALM] <= alm_chg ||
            (pend_q[EV_ALM] && !hit_pend);
         pend_q[EV_LOSS] <= loss_chg ||
            (pend_q[EV_LOSS] && !hit_pend);
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         INT_A_O <= 1'b0;
         INT_B_O <= 1'b0;
      end else begin
         INT_A_O <= (pend_q[EV_ALM] && ctrl_q[CTL_ALM_A]) ||
            (pend_q[EV_LOSS] && ctrl_q[CTL_LOSS_A]);
         INT_B_O <= (pend_q[EV_ALM] && ctrl_q[CTL_ALM_B]) ||
            (pend_q[EV_LOSS] && ctrl_q[CTL_LOSS_B]);
      end
   end

   assign PTR_STATE_O = state_q;
   assign PTR_VALUE_O = cur_q;

   // checks
   a_ais_entry: assert property (@(posedge CLK_I) disable iff (RST_I)
      eval && p_ais && ais_cnt_q == 2'h2 |=> state_q == ST_AIS)
      else $error("alarm state not entered after three alarm pointers");
   a_lop_entry: assert property (@(posedge CLK_I) disable iff (RST_I)
      eval && !valid && inv_cnt_q == 4'h7 && !ais3 && !norm3 &&
      state_q != ST_LOP |=> state_q == ST_LOP)
      else $error("lost state not entered after eight invalid frames");
   a_pointer_normal_state_entry: assert property (@(posedge CLK_I) disable iff (RST_I)
      eval && p_pointer_normal_state && prim_q.value == cand_q && pointer_normal_state_cnt_q == 2'h2 &&
      !ais3 |=> state_q == ST_POINTER_NORMAL_STATE && cur_q == $past(prim_q.value))
      else $error("normal state not taken after three equal pointers");
   a_ndf_take: assert property (@(posedge CLK_I) disable iff (RST_I)
      eval && state_q == ST_POINTER_NORMAL_STATE && p_ndf && !ais3 |=>
      cur_q == $past(prim_q.value) && hold_q == 2'h3)
      else $error("new data pointer not taken in one frame");
   a_inc_step: assert property (@(posedge CLK_I) disable iff (RST_I)
      eval && inc_ok && !norm3 && !ais3 |=>
      cur_q == (($past(cur_q) == 10'h30e) ? 10'h000 : $past(cur_q) + 10'h001))
      else $error("increment did not step the pointer");
   a_hold_block: assert property (@(posedge CLK_I) disable iff (RST_I)
      hold_q != 2'h0 && eval |-> !inc_ok && !dec_ok)
      else $error("justification accepted during holdoff");
   a_alarm_latch: assert property (@(posedge CLK_I) disable iff (RST_I)
      $changed(state_q == ST_AIS) |=> latch_q[0] && pend_q[0])
      else $error("alarm change not latched");
   a_loss_route: assert property (@(posedge CLK_I) disable iff (RST_I)
      pend_q[1] && ctrl_q[3] |=> INT_A_O)
      else $error("loss pending not routed to output a");
   a_sdh_size: assert property (@(posedge CLK_I) disable iff (RST_I)
      eval && sdh && prim_q.size != 2'h2 |-> !p_pointer_normal_state && !p_ndf)
      else $error("sdh pointer with bad size bits accepted");
   a_ais_code: assert property (@(posedge CLK_I) disable iff (RST_I)
      eval && prim_seen_q && prim_q == 16'hffff |-> p_ais && !p_pointer_normal_state)
      else $error("all-ones pointer not seen as alarm");
endmodule

/* src/sspi_pkg.sv */
/*
 * shared constants and types of the receive pointer interpreter:
 * register map, field layout, pointer codes, frame persistence counts.
 * assumes a 32-bit classic wishbone slave and one framer clock domain.
 */
package sspi_pkg;
   // pointer word as it arrives from the framer
   typedef struct packed {
      logic [3:0] flag;
      logic [1:0] size;
      logic [9:0] value;
   } sspi_ptrw_t;

   // pointer tracking states, one-hot
   typedef enum logic [2:0] {
      ST_POINTER_NORMAL_STATE = 3'b001,
      ST_LOP = 3'b010,
      ST_AIS = 3'b100
   } sspi_state_t;

   localparam logic [3:0] FLAG_NORMAL = 4'h6;
   localparam logic [3:0] FLAG_NDF = 4'h9;
   localparam logic [1:0] SIZE_SDH = 2'h2;
   localparam logic [15:0] WORD_AIS = 16'hffff;
   localparam logic [9:0] VALUE_ONES = 10'h3ff;
   localparam logic [9:0] VALUE_MAX = 10'h30e;
   localparam logic [9:0] VALUE_ZERO = 10'h000;
   localparam logic [9:0] I_BITS = 10'h2aa;
   localparam logic [9:0] D_BITS = 10'h155;
   localparam logic [3:0] SONET_MAX_DIFF = 4'h2;
   localparam logic [3:0] SDH_MAJ = 4'h3;
   localparam logic [7:0] WORDS_SONET = 8'hc0;
   localparam logic [7:0] WORDS_SDH = 8'h40;

   localparam logic [1:0] PERSIST_3 = 2'h3;
   localparam logic [3:0] PERSIST_8 = 4'h8;
   localparam logic [1:0] HOLDOFF_FRAMES = 2'h3;

   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_LATCH = 8'h04;
   localparam logic [7:0] REG_PEND = 8'h08;
   localparam logic [7:0] REG_PTR = 8'h0c;

   // control fields
   localparam int CTL_SDH = 0;
   localparam int CTL_ALM_A = 1;
   localparam int CTL_ALM_B = 2;
   localparam int CTL_LOSS_A = 3;
   localparam int CTL_LOSS_B = 4;
   localparam int CTL_W = 5;
   localparam logic [4:0] CTRL_RESET = 5'h00;

   // latched and pending fields
   localparam int EV_ALM = 0;
   localparam int EV_LOSS = 1;

   // pointer register fields
   localparam int PTR_STATE_LSB = 12;
endpackage

/* verif/sspi_frame_src.sv */
/*
 * framer-side source of h1/h2 pointer words for the interpreter.
 * assumes one clock shared with the core; drives just after rising edges.
 */
`timescale 1ns/1ns
module sspi_frame_src (
   // clock
   input wire logic clk_i,
   // pointer link
   output sspi_pkg::sspi_ptrw_t word_o,
   output logic valid_o,
   output logic first_o,
   output logic frame_end_o
);
   import sspi_pkg::*;

   initial begin
      word_o = '0;
      valid_o = 1'b0;
      first_o = 1'b0;
      frame_end_o = 1'b0;
   end

   // gap idles between words show that slow delivery is legal;
   // the idle word toggles so a stale value is never mistaken for data
   task automatic send_frame(input sspi_ptrw_t w, input logic sdh,
      input int gap);
      sspi_ptrw_t ci;
      ci = {FLAG_NORMAL, sdh ? SIZE_SDH : 2'h0, VALUE_ONES};
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_i);
         word_o <= (k == 0) ? w : ci;
         valid_o <= 1'b1;
         first_o <= (k == 0);
         repeat (gap) begin
            @(posedge clk_i);
            valid_o <= 1'b0;
            word_o <= ~word_o;
         end
      end
      @(posedge clk_i);
      valid_o <= 1'b0;
      first_o <= 1'b0;
      word_o <= ~word_o;
      frame_end_o <= 1'b1;
      @(posedge clk_i);
      frame_end_o <= 1'b0;
      word_o <= ~word_o;
      // state, latch and interrupt settle over three edges
      repeat (3) @(posedge clk_i);
   endtask
endmodule

/* verif/sspi_tb_top.sv */
/*
 * self-checking bench for the pointer interpreter core.
 * assumes the frame source model and the one-cycle wishbone ack.
 */
`timescale 1ns/1ns
module sspi_tb_top;
   import sspi_pkg::*;
   logic clk, rst, cyc, stb, we, ack, int_a, int_b, pvalid, pfirst, fend;
   logic sdh;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, seed;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [9:0] v, v1, w, pval;
   sspi_ptrw_t pword;
   sspi_state_t st;
   int num_errors, checked;

   sspi_core dut (.CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb),
      .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat),
      .ACK_O(ack), .PTR_WORD_I(pword), .PTR_VALID_I(pvalid),
      .PTR_FIRST_I(pfirst), .FRAME_END_I(fend), .PTR_STATE_O(st),
      .PTR_VALUE_O(pval), .INT_A_O(int_a), .INT_B_O(int_b));
   sspi_frame_src src (.clk_i(clk), .word_o(pword), .valid_o(pvalid),
      .first_o(pfirst), .frame_end_o(fend));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   function automatic logic [9:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return 10'(seed % 32'd783);
   endfunction

   function automatic logic [31:0] preg(input sspi_state_t s,
      input logic [9:0] val);
      return {17'h0, s, 2'h0, val};
   endfunction

   function automatic logic [9:0] up(input logic [9:0] val);
      return (val == VALUE_MAX) ? VALUE_ZERO : val + 10'h001;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // for reads d is the expected word and m the bits that matter
   task automatic wb(input logic w_en, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] m);
      int n;
      n = 0;
      if (!w_en) begin
         exp_q.push_back(d & m);
         msk_q.push_back(m);
      end
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      adr <= a;
      we <= w_en;
      wdat <= d;
      sel <= 4'hf;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) begin
         num_errors++;
      end
   endtask

   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
         check(rdat & msk_q.pop_front(), exp_q.pop_front());
      end
   end

   task automatic frames(input logic [3:0] f, input logic [1:0] s,
      input logic [9:0] val, input int n);
      repeat (n) begin
         src.send_frame({f, s, val}, sdh, int'(seed[1:0]));
         void'(rnd());
      end
   endtask

   initial begin
      #(20000 * 40);
      num_errors++;
      report_and_stop();
   end

   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0;
      seed = 32'd13;
      sdh = 1'b0;
      num_errors = 0;
      checked = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      wb(0, REG_CTRL, 32'h0, '1);
      wb(0, REG_PTR, preg(ST_LOP, VALUE_ZERO), '1);
      wb(1, 8'h10, 32'hffffffff, '1);
      wb(0, 8'h10, 32'h0, '1);
      // alarm routed to b only, loss to a only
      wb(1, REG_CTRL, 32'h0000000c, '1);
      v = rnd();
      frames(4'h4, 2'h1, v, 2);
      wb(0, REG_PTR, preg(ST_LOP, v), 32'h7000);
      frames(4'h6, 2'h2, v, 1);
      check({31'h0, int_a}, 32'h1);
      check({31'h0, int_b}, 32'h0);
      wb(0, REG_PTR, preg(ST_POINTER_NORMAL_STATE, v), '1);
      wb(0, REG_PEND, 32'h2, '1);
      wb(0, REG_LATCH, 32'h2, '1);
      wb(0, REG_LATCH, 32'h0, '1);
      check({31'h0, int_a}, 32'h0);
      frames(FLAG_NORMAL, 2'h0, v ^ I_BITS ^ 10'h004, 1);
      v1 = up(v);
      wb(0, REG_PTR, preg(ST_POINTER_NORMAL_STATE, v1), '1);
      frames(FLAG_NORMAL, 2'h0, v1 ^ D_BITS ^ 10'h002, 3);
      wb(0, REG_PTR, preg(ST_POINTER_NORMAL_STATE, v1), '1);
      frames(FLAG_NORMAL, 2'h0, v1 ^ D_BITS ^ 10'h002, 1);
      wb(0, REG_PTR, preg(ST_POINTER_NORMAL_STATE, v), '1);
      w = rnd();
      frames(4'h8, 2'h0, w, 1);
      wb(0, REG_PTR, preg(ST_POINTER_NORMAL_STATE, w), '1);
      frames(4'hf, 2'h3, VALUE_ONES, 2);
      wb(0, REG_PTR, preg(ST_POINTER_NORMAL_STATE, w), 32'h7000);
      frames(4'hf, 2'h3, VALUE_ONES, 1);
      check({31'h0, int_b}, 32'h1);
      wb(0, REG_PTR, preg(ST_AIS, w), 32'h7000);
      wb(0, REG_PEND, 32'h1, '1);
      frames(FLAG_NDF, 2'h0, w, 7);
      wb(0, REG_PTR, preg(ST_AIS, w), 32'h7000);
      frames(FLAG_NDF, 2'h0, w, 1);
      wb(0, REG_PTR, preg(ST_LOP, w), 32'h7000);
      wb(0, REG_PEND, 32'h3, '1);
      sdh = 1'b1;
      wb(1, REG_CTRL, 32'h0000000d, '1);
      wb(0, REG_CTRL, 32'h0000000d, 32'h1f);
      v = rnd();
      frames(FLAG_NORMAL, 2'h0, v, 3);
      wb(0, REG_PTR, preg(ST_LOP, v), 32'h7000);
      frames(FLAG_NORMAL, SIZE_SDH, v, 3);
      wb(0, REG_PTR, preg(ST_POINTER_NORMAL_STATE, v), '1);
      frames(FLAG_NORMAL, SIZE_SDH, v ^ 10'h0a8 ^ 10'h001, 1);
      wb(0, REG_PTR, preg(ST_POINTER_NORMAL_STATE, up(v)), '1);
      report_and_stop();
   end
endmodule
